// *** logic/csw_pkg.sv ***
package csw_pkg;
   // Register addresses on the plain register port
   localparam logic [7:0] ADDR_SWITCH = 8'h96;
   localparam logic [7:0] ADDR_ENABLE = 8'h97;
   localparam logic [7:0] ADDR_TA = 8'hC7;
   localparam logic [7:0] ADDR_IRQ_STATUS = 8'hA0;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'hA1;
   // Field positions
   localparam int FAST_ST_BIT = 5;
   localparam int SLOW_ST_BIT = 4;
   localparam int EXT_ST_BIT = 3;
   localparam int SEL_HI = 2;
   localparam int SEL_LO = 1;
   localparam int EXTEN_HI = 7;
   localparam int EXTEN_LO = 6;
   localparam int FAST_EN_BIT = 5;
   localparam int FAULT_BIT = 0;
   // Reset value and external enable code
   localparam logic [7:0] ENABLE_RESET = 8'h30;
   localparam logic [1:0] EXTEN_ON = 2'h3;
   // Timed-access unlock keys and window length
   localparam logic [7:0] TA_KEY1 = 8'hAA;
   localparam logic [7:0] TA_KEY2 = 8'h55;
   localparam int TA_WINDOW_CYCLES = 4;
   // Interrupt status bits
   localparam int IRQ_SWITCH_DONE = 0;
   localparam int IRQ_SWITCH_FAULT = 1;
   localparam int IRQ_BITS = 2;

   typedef enum logic [1:0] {
      CSW_SRC_FAST = 2'b00,
      CSW_SRC_EXT = 2'b01,
      CSW_SRC_SLOW = 2'b10,
      CSW_SRC_RSVD = 2'b11
   } csw_src_t;

   typedef struct packed {
      logic fast;
      logic slow;
      logic ext;
   } csw_stable_t;
endpackage

// *** logic/csw_sync.sv ***
`timescale 1ns/1ps
// Three-stage synchroniser; output changes when stages two and three agree
module csw_sync #(
   parameter int WIDTH = 3
) (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] stage2;
   logic [WIDTH-1:0] stage3;
   wire [WIDTH-1:0] agree = ~(stage2 ^ stage3);
   wire [WIDTH-1:0] next_out = (agree & stage3) | (~agree & sync_out);

   // Elaboration check on the width
   if (WIDTH < 1) begin : g_bad_width
      $error("csw_sync width must be positive");
   end

   // Capture chain and filtered output
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         stage1 <= '0;
         stage2 <= '0;
         stage3 <= '0;
         sync_out <= '0;
      end else begin
         stage1 <= async_in;
         stage2 <= stage1;
         stage3 <= stage2;
         sync_out <= next_out;
      end
   end
endmodule // csw_sync

// *** logic/csw_clock_switch.sv ***
// Added by the designer: strobed register access.
`timescale 1ns/1ps
// How it works
// - Fast status set only when enabled and stable
// - Bit 3 reads external enabled and stable
// - Select 00 fast, 01 external, 10 slow
// - Select field reads back the last written code
// - External input enabled only by code 11
// - Other codes release pin to GPIO
// - Bit 5 switches fast oscillator on/off
// - Programming enable forces fast oscillator on
// - Fault flag read-only, reports last switch
// - Pending switch completes when source stabilises
module csw_clock_switch (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic inapp_program_enable,
   input wire logic fast_osc_ready,
   input wire logic slow_osc_ready,
   input wire logic ext_clock_ready,
   output logic [1:0] active_source,
   output logic fast_osc_on,
   output logic crystal_in_enable,
   output logic shared_gpio_release,
   output logic irq
);
   // Stability inputs come from other clock domains
   logic [2:0] ready_sync;
   csw_sync #(.WIDTH(3)) u_sync (
      .clock(clock),
      .sys_rst(sys_rst),
      .async_in({fast_osc_ready, slow_osc_ready, ext_clock_ready}),
      .sync_out(ready_sync)
   );

   // Control state
   logic [1:0] ext_input_enable;
   logic fast_osc_enable;
   logic [1:0] source_select;
   logic [1:0] pending_source;
   logic pending;
   logic switch_fault_flag;
   logic [1:0] ta_state;
   logic [2:0] ta_count;
   logic [csw_pkg::IRQ_BITS-1:0] irq_status;
   logic [csw_pkg::IRQ_BITS-1:0] irq_mask;
   logic iap_sync1;
   logic iap_sync2;
   logic iap_sync3;
   logic iap_level;

   // Programming enable from the chip control block is treated as a pin
   wire iap_next = (iap_sync2 == iap_sync3) ? iap_sync3 : iap_level;

   // Status decode
   wire fast_eff_en = fast_osc_enable | iap_level;
   wire ext_on = (ext_input_enable == csw_pkg::EXTEN_ON);
   wire fast_osc_stable = fast_eff_en & ready_sync[2];
   wire slow_osc_stable = ready_sync[1];
   wire ext_clock_stable = ext_on & ready_sync[0];

   function automatic logic src_ok(input logic [1:0] sel, input logic f, input logic s, input logic e);
      case (sel)
         csw_pkg::CSW_SRC_FAST: src_ok = f;
         csw_pkg::CSW_SRC_EXT: src_ok = e;
         csw_pkg::CSW_SRC_SLOW: src_ok = s;
         default: src_ok = 1'b0;
      endcase
   endfunction

   // Bus decode
   wire ta_open = (ta_count != 3'd0);
   wire wr_ta = reg_wr && (reg_addr == csw_pkg::ADDR_TA);
   wire wr_switch = reg_wr && ta_open && (reg_addr == csw_pkg::ADDR_SWITCH);
   wire wr_enable = reg_wr && ta_open && (reg_addr == csw_pkg::ADDR_ENABLE);
   wire wr_istat = reg_wr && (reg_addr == csw_pkg::ADDR_IRQ_STATUS);
   wire wr_imask = reg_wr && (reg_addr == csw_pkg::ADDR_IRQ_MASK);
   wire [1:0] req_src = reg_wdata[csw_pkg::SEL_HI:csw_pkg::SEL_LO];
   wire req_ok = src_ok(req_src, fast_osc_stable, slow_osc_stable, ext_clock_stable);
   wire req_rsvd = (req_src == csw_pkg::CSW_SRC_RSVD);
   wire pend_ok = src_ok(pending_source, fast_osc_stable, slow_osc_stable, ext_clock_stable);
   wire pend_done = pending && pend_ok && !wr_switch;
   wire sw_done_ev = (wr_switch && req_ok) || pend_done;
   wire sw_fault_ev = wr_switch && !req_ok;

   wire [7:0] switch_rd = {2'b00, fast_osc_stable, slow_osc_stable, ext_clock_stable,
                           source_select, 1'b0};
   // Reserved bits read back their reset pattern
   wire [7:0] enable_rd = {ext_input_enable, fast_eff_en, csw_pkg::ENABLE_RESET[4:1], switch_fault_flag};
   wire [7:0] next_rdata =
      (reg_addr == csw_pkg::ADDR_SWITCH) ? switch_rd :
      (reg_addr == csw_pkg::ADDR_ENABLE) ? enable_rd :
      (reg_addr == csw_pkg::ADDR_IRQ_STATUS) ? {6'h00, irq_status} :
      (reg_addr == csw_pkg::ADDR_IRQ_MASK) ? {6'h00, irq_mask} : 8'h00;

   // Unlock sequence: key1 then key2 opens a short window
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         ta_state <= 2'd0;
         ta_count <= 3'd0;
      end else if (wr_ta && reg_wdata == csw_pkg::TA_KEY1) begin
         ta_state <= 2'd1;
         ta_count <= 3'd0;
      end else if (wr_ta && ta_state == 2'd1 && reg_wdata == csw_pkg::TA_KEY2) begin
         ta_state <= 2'd0;
         ta_count <= 3'(csw_pkg::TA_WINDOW_CYCLES);
      end else begin
         if (wr_ta) ta_state <= 2'd0;
         if (ta_open) ta_count <= ta_count - 3'd1;
      end
   end

   // Enable register; fast enable keeps its own value under override
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         ext_input_enable <= csw_pkg::ENABLE_RESET[csw_pkg::EXTEN_HI:csw_pkg::EXTEN_LO];
         fast_osc_enable <= csw_pkg::ENABLE_RESET[csw_pkg::FAST_EN_BIT];
      end else if (wr_enable) begin
         ext_input_enable <= reg_wdata[csw_pkg::EXTEN_HI:csw_pkg::EXTEN_LO];
         if (!iap_level) fast_osc_enable <= reg_wdata[csw_pkg::FAST_EN_BIT];
      end
   end

   // Source switch and fault tracking
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         source_select <= 2'b00;
         pending_source <= 2'b00;
         pending <= 1'b0;
         switch_fault_flag <= 1'b0;
         active_source <= 2'b00;
      end else if (wr_switch) begin
         source_select <= req_src;
         pending_source <= req_src;
         pending <= !req_ok && !req_rsvd;
         switch_fault_flag <= !req_ok;
         if (req_ok) active_source <= req_src;
      end else if (pend_done) begin
         pending <= 1'b0;
         switch_fault_flag <= 1'b0;
         active_source <= pending_source;
      end
   end

   // Interrupt status: set wins over write-one clear
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         irq_status <= '0;
         irq_mask <= '0;
      end else begin
         irq_status <= (irq_status & ~(wr_istat ? reg_wdata[csw_pkg::IRQ_BITS-1:0] : 2'b00))
                       | {sw_fault_ev, sw_done_ev};
         if (wr_imask) irq_mask <= reg_wdata[csw_pkg::IRQ_BITS-1:0];
      end
   end

   // Programming enable synchroniser and registered outputs
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         iap_sync1 <= 1'b0;
         iap_sync2 <= 1'b0;
         iap_sync3 <= 1'b0;
         iap_level <= 1'b0;
         reg_rdata <= 8'h00;
         fast_osc_on <= 1'b1;
         crystal_in_enable <= 1'b0;
         shared_gpio_release <= 1'b1;
         irq <= 1'b0;
      end else begin
         iap_sync1 <= inapp_program_enable;
         iap_sync2 <= iap_sync1;
         iap_sync3 <= iap_sync2;
         iap_level <= iap_next;
         reg_rdata <= reg_rd ? next_rdata : 8'h00;
         fast_osc_on <= fast_eff_en;
         crystal_in_enable <= ext_on;
         shared_gpio_release <= !ext_on;
         irq <= |(irq_status & irq_mask);
      end
   end

   // Checks
   a_fault_on_bad: assert property (@(posedge clock) disable iff (sys_rst)
      wr_switch && !req_ok |=> switch_fault_flag) else $error("fault flag not set");
   a_fault_clear_ok: assert property (@(posedge clock) disable iff (sys_rst)
      wr_switch && req_ok |=> !switch_fault_flag && active_source == $past(req_src))
      else $error("good switch left fault");
   a_pend_complete: assert property (@(posedge clock) disable iff (sys_rst)
      pend_done |=> !switch_fault_flag && !pending) else $error("pending switch stuck");
   a_locked_write: assert property (@(posedge clock) disable iff (sys_rst)
      reg_wr && !ta_open && reg_addr == csw_pkg::ADDR_ENABLE |=> $stable(ext_input_enable))
      else $error("locked write took effect");
   a_iap_force: assert property (@(posedge clock) disable iff (sys_rst)
      iap_level |=> fast_osc_on) else $error("override not forcing fast osc");
   a_ext_pin: assert property (@(posedge clock) disable iff (sys_rst)
      ext_on |=> crystal_in_enable && !shared_gpio_release) else $error("crystal pin not enabled");
   a_gpio_back: assert property (@(posedge clock) disable iff (sys_rst)
      !ext_on |=> !crystal_in_enable && shared_gpio_release) else $error("pin not released");
   a_fast_status: assert property (@(posedge clock) disable iff (sys_rst)
      fast_osc_stable |-> fast_eff_en && ready_sync[2]) else $error("fast status wrong");
   a_ext_status: assert property (@(posedge clock) disable iff (sys_rst)
      reg_rd && reg_addr == csw_pkg::ADDR_SWITCH ##1 1'b1 |-> reg_rdata[csw_pkg::EXT_ST_BIT] == $past(ext_clock_stable))
      else $error("ext status readback wrong");
   a_restore_en: assert property (@(posedge clock) disable iff (sys_rst)
      iap_level && !wr_enable |=> $stable(fast_osc_enable)) else $error("saved enable lost");
   a_fast_switch: assert property (@(posedge clock) disable iff (sys_rst)
      !iap_level && wr_enable ##1 !iap_level |=> fast_osc_on == $past(reg_wdata[csw_pkg::FAST_EN_BIT], 2))
      else $error("fast enable not applied");
   a_sel_readback: assert property (@(posedge clock) disable iff (sys_rst)
      wr_switch |=> source_select == $past(req_src)) else $error("select not stored");

   // Further checks on the register port, status, pins, switching, unlock and interrupts
   // Idle read data is zero
   a_rd_idle_zero: assert property (@(posedge clock) disable iff (sys_rst)
      !reg_rd |=> reg_rdata == 8'h00)
      else $error("read data not zero when idle");
   // Switch register readback
   a_rd_switch: assert property (@(posedge clock) disable iff (sys_rst)
      reg_rd && reg_addr == csw_pkg::ADDR_SWITCH |=> reg_rdata == $past(switch_rd))
      else $error("switch readback wrong");
   // Enable register readback
   a_rd_enable: assert property (@(posedge clock) disable iff (sys_rst)
      reg_rd && reg_addr == csw_pkg::ADDR_ENABLE |=> reg_rdata == $past(enable_rd))
      else $error("enable readback wrong");
   // Reserved switch bits read zero
   a_rd_rsvd_hi: assert property (@(posedge clock) disable iff (sys_rst)
      reg_rd && reg_addr == csw_pkg::ADDR_SWITCH |=> reg_rdata[7:6] == 2'b00)
      else $error("reserved bits not zero");
   // Fast status low while disabled
   a_fast_st_off: assert property (@(posedge clock) disable iff (sys_rst)
      !fast_eff_en |-> !fast_osc_stable)
      else $error("fast status while disabled");
   // External status low while disabled
   a_ext_st_off: assert property (@(posedge clock) disable iff (sys_rst)
      !ext_on |-> !ext_clock_stable)
      else $error("ext status while disabled");
   // Pin owned by exactly one user
   a_gpio_excl: assert property (@(posedge clock) disable iff (sys_rst)
      crystal_in_enable != shared_gpio_release)
      else $error("pin ownership clash");
   // Only the enabling code turns the input on
   a_ext_code: assert property (@(posedge clock) disable iff (sys_rst)
      wr_enable |=> ext_on == ($past(reg_wdata[csw_pkg::EXTEN_HI:csw_pkg::EXTEN_LO]) == csw_pkg::EXTEN_ON))
      else $error("ext enable code wrong");
   // Reserved select faults without pending
   a_rsvd_sel_fault: assert property (@(posedge clock) disable iff (sys_rst)
      wr_switch && req_rsvd |=> switch_fault_flag && !pending)
      else $error("reserved select accepted");
   // Reserved select keeps the source
   a_rsvd_keep_src: assert property (@(posedge clock) disable iff (sys_rst)
      wr_switch && req_rsvd |=> $stable(active_source))
      else $error("reserved select moved source");
   // Failed switch keeps the source
   a_bad_keep_src: assert property (@(posedge clock) disable iff (sys_rst)
      wr_switch && !req_ok |=> $stable(active_source))
      else $error("failed switch moved source");
   // Pending switch lands on its target
   a_pend_src: assert property (@(posedge clock) disable iff (sys_rst)
      pend_done |=> active_source == $past(pending_source))
      else $error("pending target lost");
   // Fault held while target unstable
   a_pend_held: assert property (@(posedge clock) disable iff (sys_rst)
      pending && !pend_ok && !wr_switch |=> switch_fault_flag && pending)
      else $error("fault dropped early");
   // A pending switch always shows the fault
   a_pend_fault: assert property (@(posedge clock) disable iff (sys_rst)
      pending |-> switch_fault_flag)
      else $error("pending without fault");
   // Reserved code never in use
   a_active_legal: assert property (@(posedge clock) disable iff (sys_rst)
      active_source != csw_pkg::CSW_SRC_RSVD)
      else $error("reserved source in use");
   // Fault flag not writable
   a_fault_ro: assert property (@(posedge clock) disable iff (sys_rst)
      wr_enable && !wr_switch && !pend_done |=> $stable(switch_fault_flag))
      else $error("fault flag written");
   // Override holds the fast enable
   a_iap_hold: assert property (@(posedge clock) disable iff (sys_rst)
      iap_level |-> fast_eff_en)
      else $error("override enable missing");
   // Override shows in enable readback
   a_iap_rd: assert property (@(posedge clock) disable iff (sys_rst)
      iap_level && reg_rd && reg_addr == csw_pkg::ADDR_ENABLE |=> reg_rdata[csw_pkg::FAST_EN_BIT])
      else $error("override not read back");
   // Override shows in fast status
   a_iap_status: assert property (@(posedge clock) disable iff (sys_rst)
      iap_level && ready_sync[2] |-> fast_osc_stable)
      else $error("override status missing");
   // Release restores the saved enable
   a_restore_out: assert property (@(posedge clock) disable iff (sys_rst)
      $fell(iap_level) |=> fast_osc_on == $past(fast_osc_enable))
      else $error("saved enable not restored");
   // Window never longer than its length
   a_ta_len: assert property (@(posedge clock) disable iff (sys_rst)
      ta_count <= 3'(csw_pkg::TA_WINDOW_CYCLES))
      else $error("unlock window too long");
   // Second key opens the window
   a_ta_open: assert property (@(posedge clock) disable iff (sys_rst)
      wr_ta && ta_state == 2'd1 && reg_wdata == csw_pkg::TA_KEY2 |=> ta_count == 3'(csw_pkg::TA_WINDOW_CYCLES))
      else $error("unlock window not opened");
   // Open window counts down
   a_ta_count: assert property (@(posedge clock) disable iff (sys_rst)
      ta_open && !wr_ta |=> ta_count == $past(ta_count) - 3'd1)
      else $error("unlock window not counting");
   // Locked switch write ignored
   a_locked_switch: assert property (@(posedge clock) disable iff (sys_rst)
      reg_wr && !ta_open && reg_addr == csw_pkg::ADDR_SWITCH |=> $stable(source_select))
      else $error("locked switch write took effect");
   // Locked fast enable write ignored
   a_locked_fast: assert property (@(posedge clock) disable iff (sys_rst)
      reg_wr && !ta_open && reg_addr == csw_pkg::ADDR_ENABLE |=> $stable(fast_osc_enable))
      else $error("locked fast enable write took effect");
   // Interrupt output follows masked status
   a_irq_level: assert property (@(posedge clock) disable iff (sys_rst)
      1'b1 |=> irq == $past(|(irq_status & irq_mask)))
      else $error("interrupt level wrong");
   // Fault status sticky until cleared
   a_irq_sticky: assert property (@(posedge clock) disable iff (sys_rst)
      irq_status[csw_pkg::IRQ_SWITCH_FAULT] && !wr_istat |=> irq_status[csw_pkg::IRQ_SWITCH_FAULT])
      else $error("fault status lost");
   // Fault event sets status even under clear
   a_irq_fault_set: assert property (@(posedge clock) disable iff (sys_rst)
      sw_fault_ev |=> irq_status[csw_pkg::IRQ_SWITCH_FAULT])
      else $error("fault status not set");
   // Done event sets status even under clear
   a_irq_done_set: assert property (@(posedge clock) disable iff (sys_rst)
      sw_done_ev |=> irq_status[csw_pkg::IRQ_SWITCH_DONE])
      else $error("done status not set");
endmodule // csw_clock_switch

// *** verif/csw_clock_switch_tb.sv ***
`timescale 1ns/1ps
module csw_clock_switch_tb;
   logic clock, sys_rst, reg_wr, reg_rd, inapp_program_enable, fast_rdy, slow_rdy, ext_rdy;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, rd_val;
   logic [1:0] active_source;
   logic fast_osc_on, crystal_in_enable, shared_gpio_release, irq;
   int n_mismatch, checked, i;

   csw_clock_switch csw_clock_switch_i (
      .clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .inapp_program_enable(inapp_program_enable),
      .fast_osc_ready(fast_rdy), .slow_osc_ready(slow_rdy), .ext_clock_ready(ext_rdy),
      .active_source(active_source), .fast_osc_on(fast_osc_on), .crystal_in_enable(crystal_in_enable),
      .shared_gpio_release(shared_gpio_release), .irq(irq));

   // Clock at 40 MHz
   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end

   task test_done;
      $display("mismatches %0d checks %0d", n_mismatch, checked);
      if (n_mismatch == 0 && checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task cmp(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask

   // Waits n edges, then steps off the edge so outputs are settled
   task tick(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask

   // One-cycle strobes with a gap cycle after each
   task wr(input logic [7:0] a, input logic [7:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
      @(posedge clock);
   endtask

   task rd(input logic [7:0] a, output logic [7:0] d);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
      @(posedge clock);
   endtask

   task chk(input logic [7:0] a, input logic [7:0] exp);
      rd(a, rd_val);
      cmp(rd_val, exp);
   endtask

   // Key pair opens the window, then the protected write
   task prot_wr(input logic [7:0] a, input logic [7:0] d);
      wr(csw_pkg::ADDR_TA, csw_pkg::TA_KEY1);
      wr(csw_pkg::ADDR_TA, csw_pkg::TA_KEY2);
      wr(a, d);
   endtask

   // Requests a source, then checks the source in use and the enable register
   task sw(input logic [1:0] code, input logic [1:0] src, input logic [7:0] en);
      prot_wr(csw_pkg::ADDR_SWITCH, {5'h00, code, 1'b0});
      tick(2);
      cmp({6'h00, active_source}, {6'h00, src});
      chk(csw_pkg::ADDR_ENABLE, en);
   endtask

   // Hang guard
   initial begin
      #500000;
      n_mismatch++;
      test_done;
   end

   // Main sequence
   initial begin
      n_mismatch = 0;
      checked = 0;
      sys_rst = 1'b1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      inapp_program_enable = 1'b0;
      fast_rdy = 1'b1;
      slow_rdy = 1'b1;
      ext_rdy = 1'b0;
      repeat (4) @(posedge clock);
      sys_rst <= 1'b0;
      tick(8);
      cmp({5'h00, fast_osc_on, crystal_in_enable, shared_gpio_release}, 8'h05);
      chk(csw_pkg::ADDR_SWITCH, 8'h30);
      chk(csw_pkg::ADDR_ENABLE, 8'h30);
      chk(8'h50, 8'h00);
      wr(csw_pkg::ADDR_ENABLE, 8'hC0);
      chk(csw_pkg::ADDR_ENABLE, 8'h30);
      prot_wr(csw_pkg::ADDR_ENABLE, 8'hC0);
      tick(2);
      cmp({5'h00, fast_osc_on, crystal_in_enable, shared_gpio_release}, 8'h02);
      chk(csw_pkg::ADDR_SWITCH, 8'h10);
      // Switch to an external source that is not yet stable
      sw(2'h1, 2'h0, 8'hD1);
      ext_rdy <= 1'b1;
      for (i = 0; i < 20 && rd_val !== 8'hD0; i++) begin
         rd(csw_pkg::ADDR_ENABLE, rd_val);
      end
      cmp(rd_val, 8'hD0);
      cmp({6'h00, active_source}, 8'h01);
      chk(csw_pkg::ADDR_SWITCH, 8'h1A);
      // Interrupt status, mask and clear
      chk(csw_pkg::ADDR_IRQ_STATUS, 8'h03);
      cmp({7'h00, irq}, 8'h00);
      wr(csw_pkg::ADDR_IRQ_MASK, 8'h02);
      tick(1);
      cmp({7'h00, irq}, 8'h01);
      wr(csw_pkg::ADDR_IRQ_STATUS, 8'h02);
      tick(1);
      cmp({7'h00, irq}, 8'h00);
      chk(csw_pkg::ADDR_IRQ_STATUS, 8'h01);
      // Non-enabling code releases the pin
      prot_wr(csw_pkg::ADDR_ENABLE, 8'h40);
      tick(2);
      cmp({5'h00, fast_osc_on, crystal_in_enable, shared_gpio_release}, 8'h01);
      chk(csw_pkg::ADDR_SWITCH, 8'h12);
      // Programming override and its release
      inapp_program_enable <= 1'b1;
      tick(10);
      cmp({7'h00, fast_osc_on}, 8'h01);
      chk(csw_pkg::ADDR_ENABLE, 8'h70);
      chk(csw_pkg::ADDR_SWITCH, 8'h32);
      inapp_program_enable <= 1'b0;
      tick(10);
      cmp({7'h00, fast_osc_on}, 8'h00);
      chk(csw_pkg::ADDR_ENABLE, 8'h50);
      // Every select code
      sw(2'h2, 2'h2, 8'h50);
      sw(2'h3, 2'h2, 8'h51);
      sw(2'h0, 2'h2, 8'h51);
      prot_wr(csw_pkg::ADDR_ENABLE, 8'h20);
      sw(2'h0, 2'h0, 8'h30);
      sw(2'h1, 2'h0, 8'h31);
      test_done;
   end
endmodule // csw_clock_switch_tb
